// ---- rtl/adc_feedback_compensation_gate_fault.sv ----
// Purpose: A/D two-point correction and gate shutdown for a motor engine
// Assumes: Converter delivers 12-bit samples with channel tags, one clock
// Notes:   Channel 1 high reference, channel 2 low reference
`timescale 1ns/1ps
module adc_feedback_compensation_gate_fault (
    input  wire logic                  CLOCK,
    input  wire logic                  RST,
    input  wire logic                  CLOCK_EN,
    input  wire logic [31:0]           S_AXI_AWADDR,
    input  wire logic                  S_AXI_AWVALID,
    output logic                       S_AXI_AWREADY,
    input  wire logic [31:0]           S_AXI_WDATA,
    input  wire logic [3:0]            S_AXI_WSTRB,
    input  wire logic                  S_AXI_WVALID,
    output logic                       S_AXI_WREADY,
    output logic [1:0]                 S_AXI_BRESP,
    output logic                       S_AXI_BVALID,
    input  wire logic                  S_AXI_BREADY,
    input  wire logic [31:0]           S_AXI_ARADDR,
    input  wire logic                  S_AXI_ARVALID,
    output logic                       S_AXI_ARREADY,
    output logic [31:0]                S_AXI_RDATA,
    output logic [1:0]                 S_AXI_RRESP,
    output logic                       S_AXI_RVALID,
    input  wire logic                  S_AXI_RREADY,
    input  wire adc_comp_pkg::sample_t RAW_SAMPLE,
    input  wire logic                  PWM_CYCLE,
    input  wire logic [5:0]            PWM_IN,
    input  wire logic                  FAULT_SHUTDOWN_INPUT,
    output adc_comp_pkg::sample_t      CORRECTED_SAMPLE,
    output adc_comp_pkg::gate_t        GATE,
    output logic                       SAMPLE_STROBE,
    output logic                       IRQ
);
    import adc_comp_pkg::*;

    logic [31:0] motor_control_bits;
    logic [11:0] ideal_high_reference;
    logic [11:0] ideal_low_reference;
    logic [15:0] fault_filter_count;
    logic [15:0] minimum_pulse_width;
    logic [15:0] sample_hold_delay;
    logic [15:0] correction_gain;
    logic signed [15:0] correction_offset;
    logic [3:0]  status;
    logic [3:0]  irq_enable;
    cal_state_t  cal_state;
    logic [12:0] cal_count;
    logic [23:0] sum_high;
    logic [23:0] sum_low;
    logic        started;
    logic        shutdown;
    logic [15:0] filt_count;
    logic [15:0] pwm_timer;
    logic        pulse_ok;

    // AXI write path: address and data are captured independently
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        ar_pending;
    wire         do_write = aw_held && w_held && !S_AXI_BVALID;
    wire         do_read  = S_AXI_ARVALID && S_AXI_ARREADY;
    assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
    assign S_AXI_WREADY  = !w_held && !S_AXI_BVALID;
    assign S_AXI_ARREADY = !S_AXI_RVALID;

    wire wr_known = (aw_addr <= OFS_RESULT) && (aw_addr[1:0] == 2'b00)
                  && (aw_addr != OFS_GAIN) && (aw_addr != OFS_OFFSET)
                  && (aw_addr != OFS_STATUS) && (aw_addr != OFS_RESULT);
    wire wr_ctrl   = do_write && aw_addr == OFS_CONTROL;
    wire wr_clear  = do_write && aw_addr == OFS_CLEAR;
    wire [3:0] clear_bits = wr_clear ? w_data[3:0] : 4'h0;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    wire [31:0] ctrl_new = merge(motor_control_bits, w_data, w_strb);
    wire start_req = wr_ctrl && ctrl_new[BIT_START];
    wire comp_on   = !motor_control_bits[BIT_COMP_OFF];
    wire gate_en   = motor_control_bits[BIT_GATE_EN];
    wire fault_clr = wr_ctrl && ctrl_new[BIT_FAULT_CLR];

    // Calibration: average each reference over the calibration window
    wire in_accum  = cal_state == CAL_ACCUM;
    wire take_high = in_accum && RAW_SAMPLE.valid
                   && RAW_SAMPLE.channel == 2'd1;
    wire take_low  = in_accum && RAW_SAMPLE.valid
                   && RAW_SAMPLE.channel == 2'd2;
    wire [11:0] avg_high = sum_high[CAL_SHIFT +: 12];
    wire [11:0] avg_low  = sum_low[CAL_SHIFT +: 12];
    wire [12:0] meas_diff = {1'b0, avg_high} - {1'b0, avg_low};
    wire [12:0] ideal_diff = {1'b0, ideal_high_reference}
                           - {1'b0, ideal_low_reference};
    wire [12:0] div_den = (meas_diff == 13'd0 || meas_diff[12])
                        ? 13'd1 : meas_diff;
    wire [23:0] gain_num = {1'b0, ideal_diff[11:0], 10'h000};
    wire [23:0] gain_div = gain_num / {11'h000, div_den};
    wire [15:0] new_gain = gain_div[15:0];
    wire [31:0] gain_x_low = {16'h0000, new_gain} * {20'h00000, avg_low};
    wire signed [31:0] new_ofs_w = $signed({20'h00000,
                                            ideal_low_reference})
                                 - $signed({10'h000, gain_x_low[31:10]});
    wire signed [15:0] new_ofs = new_ofs_w[15:0];
    wire bad_fit = meas_diff == 13'd0 || meas_diff[12] || ideal_diff[12]
                 || new_gain < GAIN_MIN || new_gain > GAIN_MAX
                 || new_ofs_w > 32'sd256
                 || new_ofs_w < -32'sd256;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            cal_state <= CAL_IDLE;
            cal_count <= 13'd0;
            sum_high  <= 24'd0;
            sum_low   <= 24'd0;
            started   <= 1'b0;
        end else if (CLOCK_EN) begin
            unique case (cal_state)
                CAL_IDLE: begin
                    // Window opens on a PWM boundary: whole periods only
                    if (start_req && !started) begin
                        started   <= 1'b1;
                    end
                    if (started && PWM_CYCLE) begin
                        cal_state <= CAL_ACCUM;
                    end
                end
                CAL_ACCUM: begin
                    if (take_high) begin
                        sum_high <= sum_high + {12'h000, RAW_SAMPLE.value};
                    end
                    if (take_low) begin
                        sum_low <= sum_low + {12'h000, RAW_SAMPLE.value};
                    end
                    if (PWM_CYCLE) begin
                        cal_count <= cal_count + 13'd1;
                        if (cal_count == 13'(CAL_CYCLES - 1)) begin
                            cal_state <= CAL_COMPUTE;
                        end
                    end
                end
                CAL_COMPUTE: cal_state <= CAL_DONE;
                CAL_DONE:    cal_state <= CAL_DONE;
            endcase
        end
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            correction_gain   <= 16'(GAIN_ONE);
            correction_offset <= 16'sh0000;
        end else if (CLOCK_EN && cal_state == CAL_COMPUTE) begin
            correction_gain   <= new_gain;
            correction_offset <= new_ofs;
        end
    end

    // Correction Y = K*X + B with K scaled by 1024
    wire cal_done = cal_state == CAL_DONE;
    wire [27:0] kx = {12'h000, correction_gain} * {16'h0000, RAW_SAMPLE.value};
    wire signed [19:0] y_full = $signed({2'b00, kx[27:10]})
                              + 20'(correction_offset);
    wire [11:0] y_sat = y_full < 0 ? 12'h000
                      : (y_full > $signed({8'h00, FULL_SCALE}))
                      ? FULL_SCALE : y_full[11:0];
    wire use_comp = comp_on && cal_done;
    wire [11:0] next_value = use_comp ? y_sat : RAW_SAMPLE.value;
    wire result_ok = !comp_on || cal_done;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            CORRECTED_SAMPLE <= '0;
        end else if (CLOCK_EN) begin
            CORRECTED_SAMPLE.valid   <= RAW_SAMPLE.valid && result_ok;
            CORRECTED_SAMPLE.channel <= RAW_SAMPLE.channel;
            CORRECTED_SAMPLE.value   <= next_value;
        end
    end

    // Fault filter: input must persist for the programmed count
    wire filt_hit = FAULT_SHUTDOWN_INPUT
                 && filt_count >= fault_filter_count;
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            filt_count <= 16'h0000;
            shutdown   <= 1'b0;
        end else if (CLOCK_EN) begin
            filt_count <= !FAULT_SHUTDOWN_INPUT ? 16'h0000
                        : (filt_count == 16'hFFFF ? filt_count
                        : filt_count + 16'h0001);
            if (filt_hit) begin
                shutdown <= 1'b1;
            end else if (fault_clr) begin
                shutdown <= 1'b0;
            end
        end
    end

    // Gating: released pins are undriven; shutdown forces them off
    wire drive = gate_en && !shutdown && !filt_hit;
    assign GATE.oe  = {6{drive}};
    assign GATE.out = drive ? PWM_IN : 6'h00;

    // Sample strobe after pulse width plus sample-hold delay
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            pwm_timer     <= 16'h0000;
            pulse_ok      <= 1'b0;
            SAMPLE_STROBE <= 1'b0;
        end else if (CLOCK_EN) begin
            pwm_timer     <= PWM_CYCLE ? 16'h0000
                           : (pwm_timer == 16'hFFFF ? pwm_timer
                           : pwm_timer + 16'h0001);
            pulse_ok      <= pwm_timer >= minimum_pulse_width;
            SAMPLE_STROBE <= drive
                && pwm_timer == minimum_pulse_width
                                + sample_hold_delay;
        end
    end

    // Sticky events, set wins over clear
    wire [3:0] events = {SAMPLE_STROBE, filt_hit,
                         cal_state == CAL_COMPUTE && bad_fit,
                         cal_state == CAL_COMPUTE};
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            status <= 4'h0;
        end else if (CLOCK_EN) begin
            status <= (status & ~clear_bits) | events;
        end
    end
    assign IRQ = |(status & irq_enable);

    // Register writes
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            motor_control_bits   <= 32'h0000_0000;
            ideal_high_reference <= REF_HIGH_RESET;
            ideal_low_reference  <= REF_LOW_RESET;
            fault_filter_count   <= FILTER_RESET;
            minimum_pulse_width  <= MIN_PULSE_RESET;
            sample_hold_delay    <= SH_DELAY_RESET;
            irq_enable           <= 4'h0;
        end else if (CLOCK_EN && do_write) begin
            unique case (aw_addr)
                OFS_CONTROL:    motor_control_bits <= ctrl_new
                                & ~(32'h1 << BIT_FAULT_CLR);
                OFS_IDEAL_HIGH: ideal_high_reference <= w_data[11:0];
                OFS_IDEAL_LOW:  ideal_low_reference  <= w_data[11:0];
                OFS_FILTER:     fault_filter_count   <= w_data[15:0];
                OFS_MIN_PULSE:  minimum_pulse_width  <= w_data[15:0];
                OFS_SH_DELAY:   sample_hold_delay    <= w_data[15:0];
                OFS_ENABLE:     irq_enable           <= w_data[3:0];
                default: ;
            endcase
        end
    end

    // Bus handshake state
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0;
            w_strb       <= 4'h0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= RESP_OKAY;
        end else if (CLOCK_EN) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR[7:0];
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (do_write) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP  <= (wr_known || aw_addr == OFS_CLEAR)
                              ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    wire [7:0] ra = S_AXI_ARADDR[7:0];
    wire [31:0] rd_value =
          ra == OFS_CONTROL    ? motor_control_bits
        : ra == OFS_IDEAL_HIGH ? {20'h0, ideal_high_reference}
        : ra == OFS_IDEAL_LOW  ? {20'h0, ideal_low_reference}
        : ra == OFS_GAIN       ? {16'h0, correction_gain}
        : ra == OFS_OFFSET     ? {{16{correction_offset[15]}},
                                  correction_offset}
        : ra == OFS_FILTER     ? {16'h0, fault_filter_count}
        : ra == OFS_MIN_PULSE  ? {16'h0, minimum_pulse_width}
        : ra == OFS_SH_DELAY   ? {16'h0, sample_hold_delay}
        : ra == OFS_STATUS     ? {28'h0, status}
        : ra == OFS_ENABLE     ? {28'h0, irq_enable}
        : ra == OFS_RESULT     ? {17'h0, CORRECTED_SAMPLE}
        : ra == OFS_STATE      ? {28'h0, pulse_ok, shutdown, cal_state}
        : 32'h0;
    wire rd_ok = ra <= OFS_STATE && ra[1:0] == 2'b00 && ra != OFS_CLEAR;

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA  <= 32'h0;
            S_AXI_RRESP  <= RESP_OKAY;
            ar_pending   <= 1'b0;
        end else if (CLOCK_EN) begin
            if (do_read) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RDATA  <= rd_ok ? rd_value : 32'h0;
                S_AXI_RRESP  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
            ar_pending <= 1'b0;
        end
    end

    // Checks
    sequence s_fault_held;
        FAULT_SHUTDOWN_INPUT && filt_hit;
    endsequence

    a_fault_stops_gates: assert property (@(posedge CLOCK) disable iff (RST)
        s_fault_held |-> GATE.oe == 6'h00)
        else $error("gates driven during fault");
    a_fault_latches: assert property (@(posedge CLOCK) disable iff (RST)
        CLOCK_EN && filt_hit |=> shutdown)
        else $error("fault not latched");
    a_short_ignored: assert property (@(posedge CLOCK) disable iff (RST)
        CLOCK_EN && !shutdown && !filt_hit && !fault_clr
        |=> !shutdown || $past(filt_hit))
        else $error("short fault latched");
    a_undriven_off: assert property (@(posedge CLOCK) disable iff (RST)
        !gate_en |-> GATE.oe == 6'h00 && GATE.out == 6'h00)
        else $error("gates driven while disabled");
    a_cal_starts: assert property (@(posedge CLOCK) disable iff (RST)
        CLOCK_EN && cal_state == CAL_IDLE && started && PWM_CYCLE
        |=> cal_state == CAL_ACCUM)
        else $error("calibration did not start");
    a_comp_default: assert property (@(posedge CLOCK) disable iff (RST)
        CLOCK_EN && comp_on && cal_done
        |=> CORRECTED_SAMPLE.value == $past(y_sat))
        else $error("corrected value not applied");
    a_no_early_valid: assert property (@(posedge CLOCK) disable iff (RST)
        CLOCK_EN && comp_on && !cal_done
        |=> !CORRECTED_SAMPLE.valid)
        else $error("result valid before calibration");
    a_raw_bypass: assert property (@(posedge CLOCK) disable iff (RST)
        CLOCK_EN && !comp_on
        |=> CORRECTED_SAMPLE.value == $past(RAW_SAMPLE.value))
        else $error("raw value not passed");
    a_gain_load: assert property (@(posedge CLOCK) disable iff (RST)
        CLOCK_EN && cal_state == CAL_COMPUTE
        |=> correction_gain == $past(new_gain))
        else $error("gain not stored");
    a_fault_flag: assert property (@(posedge CLOCK) disable iff (RST)
        CLOCK_EN && cal_state == CAL_COMPUTE && bad_fit
        |=> status[ST_COMP_FAULT])
        else $error("fit fault not flagged");
    a_saturate: assert property (@(posedge CLOCK) disable iff (RST)
        CLOCK_EN && use_comp && y_full < 0
        |=> CORRECTED_SAMPLE.value == 12'h000)
        else $error("negative result not clamped");
endmodule

// ---- include/adc_comp_pkg.sv ----
// Purpose: Shared constants and types for A/D compensation and gate fault
// Assumes: 32-bit AXI4-Lite register access, 250 MHz clock
// Notes:   Offsets are byte addresses of aligned words
package adc_comp_pkg;
    localparam logic [7:0]  OFS_CONTROL     = 8'h00;
    localparam logic [7:0]  OFS_IDEAL_HIGH  = 8'h04;
    localparam logic [7:0]  OFS_IDEAL_LOW   = 8'h08;
    localparam logic [7:0]  OFS_GAIN        = 8'h0C;
    localparam logic [7:0]  OFS_OFFSET      = 8'h10;
    localparam logic [7:0]  OFS_FILTER      = 8'h14;
    localparam logic [7:0]  OFS_MIN_PULSE   = 8'h18;
    localparam logic [7:0]  OFS_SH_DELAY    = 8'h1C;
    localparam logic [7:0]  OFS_STATUS      = 8'h20;
    localparam logic [7:0]  OFS_ENABLE      = 8'h24;
    localparam logic [7:0]  OFS_CLEAR       = 8'h28;
    localparam logic [7:0]  OFS_RESULT      = 8'h2C;
    localparam logic [7:0]  OFS_STATE       = 8'h30;
    localparam int          BIT_START       = 0;
    localparam int          BIT_COMP_OFF    = 9;
    localparam int          BIT_GATE_EN     = 1;
    localparam int          BIT_FAULT_CLR   = 2;
    localparam int          ST_CAL_DONE     = 0;
    localparam int          ST_COMP_FAULT   = 1;
    localparam int          ST_SHUTDOWN     = 2;
    localparam int          ST_SAMPLE       = 3;
    localparam int          CAL_CYCLES      = 4096;
    localparam int          CAL_SHIFT       = 12;
    localparam logic [11:0] FULL_SCALE      = 12'hFFF;
    localparam real         FULL_SCALE_V    = 1.2;
    localparam int          GAIN_ONE        = 1024;
    localparam logic [15:0] GAIN_MIN        = 16'h0300;
    localparam logic [15:0] GAIN_MAX        = 16'h0500;
    localparam logic signed [15:0] OFS_LIMIT = 16'sh0100;
    localparam logic [15:0] FILTER_RESET    = 16'h0010;
    localparam logic [15:0] MIN_PULSE_RESET = 16'h0040;
    localparam logic [15:0] SH_DELAY_RESET  = 16'h0020;
    localparam logic [11:0] REF_HIGH_RESET  = 12'hEAA;
    localparam logic [11:0] REF_LOW_RESET   = 12'h155;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

    typedef enum logic [1:0] {
        CAL_IDLE    = 2'b00,
        CAL_ACCUM   = 2'b01,
        CAL_COMPUTE = 2'b10,
        CAL_DONE    = 2'b11
    } cal_state_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  channel;
        logic [11:0] value;
    } sample_t;

    typedef struct packed {
        logic [5:0] out;
        logic [5:0] oe;
    } gate_t;
endpackage

// ---- tb/adc_front_model.sv ----
// Purpose: Feedback front end stand-in: PWM tick and tagged samples
// Assumes: Eight-clock PWM period with one slot per channel
// Notes:   Raw refs sit 16 counts above the ideal defaults
`timescale 1ns/1ps
module adc_front_model #(
    parameter logic [11:0] REF_H_RAW = 12'hEBA,
    parameter logic [11:0] REF_L_RAW = 12'h165
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic [11:0] data_value,
    output adc_comp_pkg::sample_t sample,
    output logic             pwm_cycle
);
    import adc_comp_pkg::*;
    logic [2:0] slot;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            slot <= 3'h0;
            pwm_cycle <= 1'b0;
            sample <= '0;
        end else begin
            slot <= slot + 3'h1;
            pwm_cycle <= (slot == 3'h7);
            case (slot)
                3'h1: sample <= '{1'b1, 2'h1, REF_H_RAW};
                3'h3: sample <= '{1'b1, 2'h2, REF_L_RAW};
                3'h5: sample <= '{1'b1, 2'h0, data_value};
                // Idle slots invert the bus word; slot 7 restores the stale slot-5 data with valid low
                default: sample <= '{1'b0, ~sample.channel, ~sample.value};
            endcase
        end
    end
endmodule

// ---- tb/adc_feedback_compensation_gate_fault_tb.sv ----
// Purpose: Register-level bench for compensation and gate shutdown
// Assumes: Front end model supplies references and data samples
// Notes:   Expected gain is 1024 and offset -16 from model refs
`timescale 1ns/1ps
module adc_feedback_compensation_gate_fault_tb;
    import adc_comp_pkg::*;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, word = 32'h0;
    logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic        fault = 1'b0, pwm_cycle, awready, wready, bvalid;
    logic        arready, rvalid, strobe, irq;
    logic [5:0]  pwm_in = 6'h2A;
    logic [11:0] data_value = 12'h800, last = 12'h000;
    logic [1:0]  bresp, rresp, resp;
    logic [31:0] rdata;
    sample_t     raw, corr;
    gate_t       gate;
    int          err_count = 0, total_checks = 0, n_valid = 0;
    always #2 clock = ~clock;
    adc_front_model i_adc_front_model (.clock(clock), .rst(rst),
        .data_value(data_value), .sample(raw), .pwm_cycle(pwm_cycle));
    adc_feedback_compensation_gate_fault i_adc_feedback_compensation_gate_fault (
        .CLOCK(clock), .RST(rst), .CLOCK_EN(1'b1),
        .S_AXI_AWADDR({24'h0, awaddr}), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
        .S_AXI_WVALID(wv), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
        .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR({24'h0, araddr}), .S_AXI_ARVALID(arv),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .RAW_SAMPLE(raw),
        .PWM_CYCLE(pwm_cycle), .PWM_IN(pwm_in), .FAULT_SHUTDOWN_INPUT(fault),
        .CORRECTED_SAMPLE(corr), .GATE(gate), .SAMPLE_STROBE(strobe),
        .IRQ(irq));
    always @(posedge clock) begin
        if (corr.valid === 1'b1 && corr.channel === 2'h0) begin
            n_valid <= n_valid + 1;
            last <= corr.value;
        end
    end
    task end_sim();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_resp(input string n, input logic [1:0] e, input logic [1:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s response expected %b seen %b", n, e, g);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awv <= 1'b0;
            if (wready) wv <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clock);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arv <= 1'b0;
        end while (rvalid !== 1'b1);
        word = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e, input string n);
        rd(a);
        chk(n, e, word);
        chk_resp(n, RESP_OKAY, resp);
    endtask
    task sample_chk(input logic [11:0] d, input logic [11:0] e);
        data_value <= d;
        repeat (20) @(posedge clock);
        chk("corrected", {20'h0, e}, {20'h0, last});
    endtask
    initial begin
        repeat (80000) @(posedge clock);
        err_count++;
        end_sim();
    end
    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rchk(OFS_CONTROL, 32'h0, "control");
        rchk(OFS_FILTER, {16'h0, FILTER_RESET}, "filter");
        rchk(OFS_IDEAL_HIGH, {20'h0, REF_HIGH_RESET}, "ideal high");
        rchk(OFS_IDEAL_LOW, {20'h0, REF_LOW_RESET}, "ideal low");
        rd(8'h40);
        chk_resp("unmapped", RESP_SLVERR, resp);
        wr(OFS_GAIN, 32'h1234);
        chk_resp("gain write", RESP_SLVERR, resp);
        chk("gates idle", 32'h0, {26'h0, gate.oe});
        wr(OFS_IDEAL_HIGH, {20'h0, REF_HIGH_RESET});
        wr(OFS_MIN_PULSE, 32'h2);
        wr(OFS_SH_DELAY, 32'h1);
        wr(OFS_ENABLE, 32'h1);
        wr(OFS_CONTROL, 32'h1);
        repeat (32000) @(posedge clock);
        chk("early samples", 32'h0, 32'(n_valid));
        for (int i = 0; i < 3000 && word[ST_CAL_DONE] !== 1'b1; i++)
            rd(OFS_STATUS);
        chk("status", 32'h1, {28'h0, word[3:0]});
        chk("irq", 32'h1, {31'h0, irq});
        rchk(OFS_GAIN, 32'h400, "gain");
        rd(OFS_OFFSET);
        chk("offset", 32'hFFF0, {16'h0, word[15:0]});
        sample_chk(12'h800, 12'h7F0);
        sample_chk(12'h005, 12'h000);
        wr(OFS_CLEAR, 32'h1);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(OFS_CONTROL, 32'h202);
        sample_chk(12'h005, 12'h005);
        sample_chk(12'hFFF, 12'hFFF);
        chk("gates", 32'hABF, {20'h0, gate});
        rd(OFS_STATUS);
        chk("strobe", 32'h8, {28'h0, word[3:0]});
        wr(OFS_ENABLE, 32'h4);
        fault <= 1'b1;
        repeat (12) @(posedge clock);
        fault <= 1'b0;
        repeat (4) @(posedge clock);
        chk("short fault", 32'h3F, {26'h0, gate.oe});
        fault <= 1'b1;
        repeat (24) @(posedge clock);
        chk("shutdown", 32'h0, {26'h0, gate.oe});
        chk("irq fault", 32'h1, {31'h0, irq});
        fault <= 1'b0;
        wr(OFS_CONTROL, 32'h206);
        repeat (2) @(posedge clock);
        chk("restart", 32'h3F, {26'h0, gate.oe});
        end_sim();
    end
endmodule
